// ===== inc/adc_fmt_pkg.sv
package adc_fmt_pkg;
  // Clock and conversion timing.
  localparam int CLK_PERIOD_NS = 25;
  // The spacing table is held in half-microsecond units.
  localparam int T_UNIT_NS = 500;
  localparam int UNIT_CYCLES = T_UNIT_NS / CLK_PERIOD_NS;
  localparam int T_CONV_NS = 600;
  localparam int CONV_CYCLES = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_SLOW_FACTOR = 32;
  localparam int GAP_W = 18;
  localparam logic [3:0] AVG_LAST = 4'hf;
  // Device address on the link, arbitrary default.
  localparam logic [6:0] DEV_ADDR = 7'h10;

  // Register offsets.
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] RESULT_ADDR = 8'h08;

  // Field positions of the configuration word.
  localparam int CFG_AUTO_BIT = 0;
  localparam int CFG_AVG_BIT = 1;
  localparam int CFG_OSC_BIT = 2;
  localparam int CFG_DIV_LSB = 4;
  localparam int CFG_TAG_LSB = 8;
  localparam int CFG_CH_LSB = 12;
  localparam int CFG_CRCERR_BIT = 16;

  // Field positions of the status word.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_STRETCH_BIT = 1;
  localparam int ST_ALERT_BIT = 2;
  localparam int ST_EVENT_LSB = 8;

  // Tag select codes and the fixed head of the status nibble.
  localparam logic [1:0] TAG_CHANNEL = 2'h1;
  localparam logic [1:0] TAG_STATUS = 2'h2;
  localparam logic [1:0] STATUS_MARK = 2'h2;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2c_in_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2c_out_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } line_evt_t;

  function automatic logic [8:0] cycle_half_us(input logic [3:0] code);
    logic [8:0] v;
    case (code)
      4'h0: v = 9'h002;
      4'h1: v = 9'h003;
      4'h2: v = 9'h004;
      4'h3: v = 9'h006;
      4'h4: v = 9'h008;
      4'h5: v = 9'h00c;
      4'h6: v = 9'h010;
      4'h7: v = 9'h018;
      4'h8: v = 9'h020;
      4'h9: v = 9'h030;
      4'ha: v = 9'h040;
      4'hb: v = 9'h060;
      4'hc: v = 9'h080;
      4'hd: v = 9'h0c0;
      4'he: v = 9'h100;
      default: v = 9'h180;
    endcase
    return v;
  endfunction
endpackage

// ===== core/i2c_line_sync.sv
`timescale 1ns/1ps
module i2c_line_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire adc_fmt_pkg::i2c_in_t line,
  output adc_fmt_pkg::line_evt_t ev
);
  import adc_fmt_pkg::*;

  typedef struct packed {
    i2c_in_t s1;
    i2c_in_t s2;
    i2c_in_t s3;
  } sync_t;

  sync_t st_reg;
  sync_t st_next;

  // The first stage feeds only the second; edges are taken from stages two and three.
  always_comb begin
    st_next.s1 = line;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ev = '{scl: st_reg.s2.scl,
                sda: st_reg.s2.sda,
                scl_rise: st_reg.s2.scl & ~st_reg.s3.scl,
                scl_fall: ~st_reg.s2.scl & st_reg.s3.scl,
                start: st_reg.s2.scl & st_reg.s3.scl & st_reg.s3.sda & ~st_reg.s2.sda,
                stop: st_reg.s2.scl & st_reg.s3.scl & ~st_reg.s3.sda & st_reg.s2.sda};
endmodule

// ===== core/adc_readout_core.sv
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - In autonomous mode the block starts every conversion itself, no host trigger.
// - With averaging the host triggers only the first conversion; the rest are internal.
// - Oscillator select 0: spacing follows the divider, 1 us up to 192 us.
// - Oscillator select 1: spacing is 32 times the select-0 value.
// - Conversion duration is fixed; settings change only the spacing of starts.
// - Raw result: bits 11..4, then bits 3..0 and four zeros.
// - Averaged result without tag: bits 15..8, then bits 7..0.
// - Raw result with tag: second byte is bits 3..0 then the tag.
// - Averaged result with tag: three bytes, last is tag then four zeros.
// - Two-bit tag select chooses channel index or status nibble.
// - Tag select 10b appends the status nibble.
// - Status nibble is 1, 0, input CRC error, alert, in that order.
// - Status CRC bit mirrors the stored input CRC error bit.
// - Status alert bit is the OR of all window event flags.
// - Serial clock is held low while the conversion completes; host must wait.
// - A CRC error on incoming bytes discards them and sets the error bit.
// - The averaging result is a 16-bit value instead of the 12-bit code.
module adc_readout_core #(
  parameter int unsigned CYCLE_UNIT = adc_fmt_pkg::UNIT_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire adc_fmt_pkg::i2c_in_t i2c_in,
  output adc_fmt_pkg::i2c_out_t i2c_out,
  output logic conv_start,
  output logic [2:0] conv_channel,
  input wire logic [11:0] adc_code,
  input wire logic crc_fault,
  input wire logic [7:0] event_flags
);
  import adc_fmt_pkg::*;

  localparam int CONV_LAST = CONV_CYCLES - 1;

  typedef enum logic [1:0] {E_IDLE, E_CONV, E_GAP} eng_t;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_STRETCH, I_TX, I_RACK} lnk_t;

  typedef struct packed {
    logic [7:0] haddr_q;
    logic wr_pend;
    logic [31:0] hrdata;
    logic rdy;
    logic resp;
    logic auto_en;
    logic avg_en;
    logic oscillator_range_select;
    logic [3:0] div;
    logic [1:0] tag_sel;
    logic [2:0] chan;
    logic crc_err;
    eng_t eng;
    logic [GAP_W-1:0] gap;
    logic [4:0] conv;
    logic [3:0] left;
    logic [15:0] acc;
    logic [15:0] result;
    logic done;
    logic conv_start;
    lnk_t lnk;
    logic [7:0] sh;
    logic [3:0] bitn;
    logic [23:0] frame;
    logic [1:0] bytes_left;
    logic req;
    logic bad;
    logic nack;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } st_t;

  st_t st_reg;
  st_t st_next;
  line_evt_t ev;
  logic alert;

  i2c_line_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .line(i2c_in),
    .ev(ev)
  );

  assign alert = |event_flags;

  function automatic logic [GAP_W-1:0] period_of(input logic osc, input logic [3:0] d);
    logic [31:0] p;
    p = 32'(cycle_half_us(d)) * 32'(CYCLE_UNIT);
    if (osc) begin
      p = p * 32'(OSC_SLOW_FACTOR);
    end
    return p[GAP_W-1:0];
  endfunction

  always_comb begin
    logic addr_ok;
    logic [31:0] rd;
    logic [15:0] sample;
    logic [15:0] sum;
    logic start_now;
    logic [3:0] tag;
    logic tag_on;
    addr_ok = hsel && htrans[1] && hready;
    rd = '0;
    sample = {4'h0, adc_code};
    sum = st_reg.acc + sample;
    start_now = 1'h0;
    tag_on = (st_reg.tag_sel == TAG_CHANNEL) || (st_reg.tag_sel == TAG_STATUS);
    tag = {1'h0, st_reg.chan};
    if (st_reg.tag_sel == TAG_STATUS) begin
      tag = {STATUS_MARK, st_reg.crc_err, alert};
    end
    st_next = st_reg;
    st_next.conv_start = 1'h0;
    st_next.done = 1'h0;

    // Bus slave: zero wait states, read data registered at the address phase.
    if (haddr[31:8] == 24'h00_0000) begin
      unique case (haddr[7:0])
        CFG_ADDR: begin
          rd[CFG_AUTO_BIT] = st_reg.auto_en;
          rd[CFG_AVG_BIT] = st_reg.avg_en;
          rd[CFG_OSC_BIT] = st_reg.oscillator_range_select;
          rd[CFG_DIV_LSB +: 4] = st_reg.div;
          rd[CFG_TAG_LSB +: 2] = st_reg.tag_sel;
          rd[CFG_CH_LSB +: 3] = st_reg.chan;
          rd[CFG_CRCERR_BIT] = st_reg.crc_err;
        end
        STATUS_ADDR: begin
          rd[ST_BUSY_BIT] = st_reg.eng != E_IDLE;
          rd[ST_STRETCH_BIT] = st_reg.scl_oe;
          rd[ST_ALERT_BIT] = alert;
          rd[ST_EVENT_LSB +: 8] = event_flags;
        end
        RESULT_ADDR: rd[15:0] = st_reg.result;
        default: rd = '0;
      endcase
    end
    st_next.wr_pend = addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
    if (addr_ok) begin
      st_next.haddr_q = haddr[7:0];
    end
    if (addr_ok && !hwrite) begin
      st_next.hrdata = rd;
    end
    // A fault arriving with the clearing write keeps the bit set.
    if (st_reg.wr_pend && st_reg.haddr_q == CFG_ADDR) begin
      st_next.auto_en = hwdata[CFG_AUTO_BIT];
      st_next.avg_en = hwdata[CFG_AVG_BIT];
      st_next.oscillator_range_select = hwdata[CFG_OSC_BIT];
      st_next.div = hwdata[CFG_DIV_LSB +: 4];
      st_next.tag_sel = hwdata[CFG_TAG_LSB +: 2];
      st_next.chan = hwdata[CFG_CH_LSB +: 3];
      st_next.crc_err = st_reg.crc_err & ~hwdata[CFG_CRCERR_BIT];
    end
    if (crc_fault) begin
      st_next.crc_err = 1'h1;
      st_next.bad = 1'h1;
    end

    // Conversion engine.
    if (st_reg.gap != '0) begin
      st_next.gap = st_reg.gap - 1'h1;
    end
    unique case (st_reg.eng)
      E_IDLE: begin
        // The request is still up in the cycle of the done pulse; it must not start a second run.
        if (st_reg.auto_en || (st_reg.req && !st_reg.done)) begin
          start_now = 1'h1;
          st_next.acc = '0;
          st_next.left = st_reg.avg_en ? AVG_LAST : 4'h0;
        end
      end
      E_CONV: begin
        if (st_reg.conv == 5'h00) begin
          if (st_reg.left == 4'h0) begin
            st_next.result = st_reg.avg_en ? sum : sample;
            st_next.done = 1'h1;
            st_next.acc = '0;
            st_next.left = st_reg.avg_en ? AVG_LAST : 4'h0;
            st_next.eng = st_reg.auto_en ? E_GAP : E_IDLE;
          end else begin
            st_next.acc = sum;
            st_next.left = st_reg.left - 4'h1;
            st_next.eng = E_GAP;
          end
        end else begin
          st_next.conv = st_reg.conv - 5'h01;
        end
      end
      E_GAP: begin
        if (!st_reg.auto_en && !st_reg.req) begin
          st_next.eng = E_IDLE;
        end else if (st_reg.gap == '0) begin
          start_now = 1'h1;
        end
      end
      default: st_next.eng = E_IDLE;
    endcase
    // Duration is fixed; the divider only reloads the spacing timer.
    if (start_now) begin
      st_next.conv_start = 1'h1;
      st_next.conv = 5'(CONV_LAST);
      st_next.gap = period_of(st_reg.oscillator_range_select, st_reg.div) - 1'h1;
      st_next.eng = E_CONV;
    end

    // Serial readout, open drain: enable high drives a zero.
    if (ev.start) begin
      st_next.lnk = I_ADDR;
      st_next.bitn = 4'h0;
      st_next.bad = 1'h0;
      st_next.sda_oe = 1'h0;
      st_next.scl_oe = 1'h0;
      st_next.req = 1'h0;
    end else if (ev.stop) begin
      st_next.lnk = I_IDLE;
      st_next.sda_oe = 1'h0;
      st_next.scl_oe = 1'h0;
      st_next.req = 1'h0;
    end else begin
      unique case (st_reg.lnk)
        I_IDLE: st_next.lnk = I_IDLE;
        I_ADDR: begin
          if (ev.scl_rise && st_reg.bitn != 4'h8) begin
            st_next.sh = {st_reg.sh[6:0], ev.sda};
            st_next.bitn = st_reg.bitn + 4'h1;
          end else if (ev.scl_fall && st_reg.bitn == 4'h8) begin
            if (st_reg.sh == {DEV_ADDR, 1'h1} && !st_reg.bad && !crc_fault) begin
              st_next.sda_oe = 1'h1;
              st_next.lnk = I_AACK;
            end else begin
              st_next.lnk = I_IDLE;
            end
          end
        end
        I_AACK: begin
          if (ev.scl_fall) begin
            st_next.sda_oe = 1'h0;
            st_next.scl_oe = 1'h1;
            st_next.req = !st_reg.auto_en;
            st_next.lnk = I_STRETCH;
          end
        end
        I_STRETCH: begin
          if (st_reg.done) begin
            if (st_reg.avg_en) begin
              st_next.frame = tag_on ? {st_reg.result, tag, 4'h0} : {st_reg.result, 8'h00};
              st_next.bytes_left = tag_on ? 2'h2 : 2'h1;
            end else begin
              st_next.frame = {st_reg.result[11:0], tag_on ? tag : 4'h0, 8'h00};
              st_next.bytes_left = 2'h1;
            end
            st_next.sda_oe = avg_en_first_zero(st_reg.avg_en, st_reg.result);
            st_next.bitn = 4'h0;
            st_next.scl_oe = 1'h0;
            st_next.req = 1'h0;
            st_next.lnk = I_TX;
          end
        end
        I_TX: begin
          if (ev.scl_fall) begin
            st_next.frame = {st_reg.frame[22:0], 1'h0};
            if (st_reg.bitn == 4'h7) begin
              st_next.sda_oe = 1'h0;
              st_next.bitn = 4'h0;
              st_next.lnk = I_RACK;
            end else begin
              st_next.sda_oe = ~st_reg.frame[22];
              st_next.bitn = st_reg.bitn + 4'h1;
            end
          end
        end
        I_RACK: begin
          if (ev.scl_rise) begin
            st_next.nack = ev.sda;
          end else if (ev.scl_fall) begin
            if (st_reg.nack) begin
              st_next.lnk = I_IDLE;
            end else if (st_reg.bytes_left != 2'h0) begin
              st_next.bytes_left = st_reg.bytes_left - 2'h1;
              st_next.sda_oe = ~st_reg.frame[23];
              st_next.lnk = I_TX;
            end else begin
              st_next.scl_oe = 1'h1;
              st_next.req = !st_reg.auto_en;
              st_next.lnk = I_STRETCH;
            end
          end
        end
        default: st_next.lnk = I_IDLE;
      endcase
    end
  end

  // Top bit of the new frame: bit 15 when averaging, else bit 11.
  function automatic logic avg_en_first_zero(input logic avg, input logic [15:0] res);
    return avg ? ~res[15] : ~res[11];
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.rdy <= 1'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.hrdata;
  assign hreadyout = st_reg.rdy;
  assign hresp = st_reg.resp;
  assign i2c_out = '{scl_oe: st_reg.scl_oe, sda_o: st_reg.sda_o, sda_oe: st_reg.sda_oe};
  assign conv_start = st_reg.conv_start;
  assign conv_channel = st_reg.chan;

  // Helper: cycles since the last start, armed while autonomous and untouched.
  logic [GAP_W:0] since_q;
  logic armed_q;
  logic wr_d;

  function automatic int exp_half_us(input logic [3:0] d);
    return d[0] ? (3 << d[3:1]) : (2 << d[3:1]);
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_q <= '0;
      armed_q <= 1'h0;
      wr_d <= 1'h0;
    end else begin
      wr_d <= st_reg.wr_pend;
      // A start launched in the cycle of a write still used the old spacing.
      if (st_reg.conv_start) begin
        since_q <= 19'h0_0001;
        armed_q <= st_reg.auto_en && !wr_d;
      end else if (since_q != '1) begin
        since_q <= since_q + 1'h1;
      end
      if (st_reg.wr_pend) begin
        armed_q <= 1'h0;
      end
    end
  end

  property p_auto_start;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.auto_en && st_reg.eng == E_IDLE) |=> conv_start;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("autonomous start missing");

  property p_manual_first;
    @(posedge hclk) disable iff (!hresetn)
    (!st_reg.auto_en && st_reg.req && !st_reg.done && st_reg.eng == E_IDLE)
      |=> conv_start ##1 (st_reg.left == (st_reg.avg_en ? AVG_LAST : 4'h0));
  endproperty
  a_manual_first: assert property (p_manual_first) else $error("host-triggered run start wrong");

  property p_spacing_fast;
    @(posedge hclk) disable iff (!hresetn)
    (conv_start && armed_q && !st_reg.oscillator_range_select && exp_half_us(st_reg.div) * CYCLE_UNIT > CONV_CYCLES)
      |-> (since_q == 19'(exp_half_us(st_reg.div) * CYCLE_UNIT));
  endproperty
  a_spacing_fast: assert property (p_spacing_fast) else $error("start spacing wrong at select 0");

  property p_spacing_slow;
    @(posedge hclk) disable iff (!hresetn)
    (conv_start && armed_q && st_reg.oscillator_range_select) |-> (since_q == 19'(exp_half_us(st_reg.div) * CYCLE_UNIT * 32));
  endproperty
  a_spacing_slow: assert property (p_spacing_slow) else $error("start spacing wrong at select 1");

  property p_conv_len;
    @(posedge hclk) disable iff (!hresetn)
    conv_start |-> ##CONV_LAST (st_reg.eng == E_CONV && st_reg.conv == 5'h00) ##1 (st_reg.eng != E_CONV);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length not fixed");

  property p_raw_plain;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.lnk == I_STRETCH && st_reg.done && !st_reg.avg_en && !((st_reg.tag_sel == TAG_CHANNEL) || (st_reg.tag_sel == TAG_STATUS)))
      |=> (st_reg.frame[23:8] == {st_reg.result[11:0], 4'h0} && st_reg.bytes_left == 2'h1);
  endproperty
  a_raw_plain: assert property (p_raw_plain) else $error("raw frame layout wrong");

  property p_avg_plain;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.lnk == I_STRETCH && st_reg.done && st_reg.avg_en && st_reg.tag_sel[1] == st_reg.tag_sel[0])
      |=> (st_reg.frame[23:8] == st_reg.result && st_reg.bytes_left == 2'h1);
  endproperty
  a_avg_plain: assert property (p_avg_plain) else $error("averaged frame layout wrong");

  property p_status_tag;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.lnk == I_STRETCH && st_reg.done && !st_reg.avg_en && st_reg.tag_sel == TAG_STATUS)
      |=> (st_reg.frame[11:8] == {2'h2, $past(st_reg.crc_err), |$past(event_flags)});
  endproperty
  a_status_tag: assert property (p_status_tag) else $error("status nibble wrong");

  property p_avg_tag;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.lnk == I_STRETCH && st_reg.done && st_reg.avg_en && st_reg.tag_sel == TAG_CHANNEL)
      |=> (st_reg.frame == {st_reg.result, 1'h0, st_reg.chan, 4'h0} && st_reg.bytes_left == 2'h2);
  endproperty
  a_avg_tag: assert property (p_avg_tag) else $error("tagged averaged frame wrong");

  property p_stretch;
    @(posedge hclk) disable iff (!hresetn)
    (st_reg.lnk == I_AACK && ev.scl_fall && !ev.start && !ev.stop) |=> (st_reg.scl_oe throughout (st_reg.lnk == I_STRETCH)[*2]);
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock not held during conversion");

  property p_crc_set;
    @(posedge hclk) disable iff (!hresetn)
    crc_fault |=> st_reg.crc_err ##1 (st_reg.crc_err || $past(st_reg.wr_pend));
  endproperty
  a_crc_set: assert property (p_crc_set) else $error("input CRC error bit not set");
endmodule

// ===== sim/i2c_host_model.sv
`timescale 1ns/1ps
module i2c_host_model (
  input wire logic hclk,
  input wire adc_fmt_pkg::i2c_out_t i2c_out,
  output adc_fmt_pkg::i2c_in_t i2c_in
);
  import adc_fmt_pkg::*;
  logic scl_low;
  logic sda_low;
  int stalls;
  // Both lines have pull-ups, so a released line reads high.
  assign i2c_in.scl = ~(scl_low | i2c_out.scl_oe);
  assign i2c_in.sda = ~(sda_low | i2c_out.sda_oe);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stalls = 0;
  end
  task automatic do_bit(input logic b_out, output logic b_in);
    int n;
    n = 0;
    repeat (2) @(posedge hclk);
    sda_low <= ~b_out;
    repeat (2) @(posedge hclk);
    scl_low <= 1'b0;
    @(posedge hclk);
    // The device may hold SCL low until its conversion is done, so wait for the line.
    while (i2c_in.scl !== 1'b1 && n < 30000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 30000) begin
      stalls++;
    end
    repeat (4) @(posedge hclk);
    b_in = i2c_in.sda;
    scl_low <= 1'b1;
  endtask
  // The host only starts the read; every further conversion is the device's own.
  task automatic read_frame(input int nb, output logic [23:0] data, output logic ack);
    logic [7:0] a;
    logic bt;
    int i;
    int k;
    a = {DEV_ADDR, 1'b1};
    data = '0;
    sda_low <= 1'b1;
    repeat (4) @(posedge hclk);
    scl_low <= 1'b1;
    for (i = 7; i >= 0; i--) begin
      do_bit(a[i], bt);
    end
    do_bit(1'b1, bt);
    ack = ~bt;
    for (k = 0; k < nb; k++) begin
      for (i = 0; i < 8; i++) begin
        do_bit(1'b1, bt);
        data = {data[22:0], bt};
      end
      do_bit(k == nb - 1, bt);
    end
    repeat (2) @(posedge hclk);
    sda_low <= 1'b1;
    repeat (2) @(posedge hclk);
    scl_low <= 1'b0;
    repeat (4) @(posedge hclk);
    sda_low <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import adc_fmt_pkg::*;
  localparam int unsigned UNIT = 13;
  localparam int TAB[16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256, 384};
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  i2c_in_t i2c_in;
  i2c_out_t i2c_out;
  logic conv_start;
  logic [2:0] conv_channel;
  logic [11:0] adc_code;
  logic crc_fault;
  logic [7:0] event_flags;
  int n_fail;
  int check_count;
  logic [31:0] seed;
  logic [31:0] rnd;
  logic [11:0] codes[$];

  adc_readout_core #(.CYCLE_UNIT(UNIT)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .i2c_in(i2c_in), .i2c_out(i2c_out), .conv_start(conv_start),
    .conv_channel(conv_channel), .adc_code(adc_code), .crc_fault(crc_fault), .event_flags(event_flags));
  i2c_host_model u_host (.hclk(hclk), .i2c_out(i2c_out), .i2c_in(i2c_in));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic gap(output int n);
    int w;
    w = 0;
    while (conv_start !== 1'b1 && w < 20000) begin
      @(posedge hclk);
      w++;
    end
    @(posedge hclk);
    n = 1;
    while (conv_start !== 1'b1 && n < 20000) begin
      @(posedge hclk);
      n++;
    end
  endtask

  // The analog side hands a fresh random code for every conversion the device starts.
  always @(posedge hclk) begin
    if (conv_start === 1'b1) begin
      rnd = xs();
      adc_code <= rnd[11:0];
      codes.push_back(rnd[11:0]);
    end
  end

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    repeat (100000) @(posedge hclk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    logic [31:0] q;
    logic [23:0] data;
    logic [23:0] exp;
    logic ack;
    logic [2:0] ch;
    logic [1:0] tag;
    logic [3:0] tn;
    logic [7:0] ev;
    logic avg;
    logic crc;
    int i;
    int n;
    int nb;
    int sum;
    n_fail = 0;
    check_count = 0;
    seed = 32'd55796;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    adc_code = '0;
    crc_fault = 1'b0;
    event_flags = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b1, 32'h0000_0100, 32'hffff_ffff, q);
    ahb(1'b0, 32'h0000_0100, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    chk(32'(hresp), 32'h0000_0000);
    // Sixteen divider codes at the fast range, then two at the slow range.
    for (i = 0; i < 18; i++) begin
      n = (i >= 16) ? i - 16 : i;
      ahb(1'b1, 32'(CFG_ADDR), 32'(1 + ((i >= 16) << CFG_OSC_BIT) + (n << CFG_DIV_LSB)), q);
      gap(nb);
      gap(nb);
      chk(32'(nb), 32'(TAB[n] * UNIT * ((i >= 16) ? OSC_SLOW_FACTOR : 1)));
    end
    for (i = 0; i < 8; i++) begin
      tag = i[1:0];
      avg = i[2];
      rnd = xs();
      ch = rnd[2:0];
      crc = i[1] ^ i[2];
      ev = i[2] ? (rnd[15:8] | 8'h80) : 8'h00;
      event_flags <= ev;
      ahb(1'b1, 32'(CFG_ADDR), 32'((avg << CFG_AVG_BIT) + (tag << CFG_TAG_LSB) + (ch << CFG_CH_LSB) + 32'h1_0000), q);
      repeat (30) @(posedge hclk);
      if (crc) begin
        crc_fault <= 1'b1;
        @(posedge hclk);
        crc_fault <= 1'b0;
      end
      @(posedge hclk);
      ahb(1'b0, 32'(CFG_ADDR), 32'h0000_0000, q);
      chk(32'(q[CFG_CRCERR_BIT]), 32'(crc));
      ahb(1'b0, 32'(STATUS_ADDR), 32'h0000_0000, q);
      chk(32'({q[15:8], q[ST_ALERT_BIT]}), 32'({ev, |ev}));
      codes.delete();
      nb = (avg && (tag == TAG_CHANNEL || tag == TAG_STATUS)) ? 3 : 2;
      u_host.read_frame(nb, data, ack);
      chk(32'(ack), 32'h0000_0001);
      chk(32'(codes.size()), avg ? 32'h0000_0010 : 32'h0000_0001);
      sum = 0;
      foreach (codes[k]) sum += codes[k];
      tn = (tag == TAG_CHANNEL) ? {1'b0, ch} : (tag == TAG_STATUS) ? {STATUS_MARK, crc, |ev} : 4'h0;
      if (avg) begin
        exp = (nb == 3) ? {sum[15:0], tn, 4'h0} : {8'h00, sum[15:0]};
      end else begin
        exp = {8'h00, sum[11:0], tn};
      end
      chk(32'(data), 32'(exp));
      ahb(1'b0, 32'(RESULT_ADDR), 32'h0000_0000, q);
      chk(q, avg ? 32'(sum[15:0]) : 32'(sum[11:0]));
      chk(32'(conv_channel), 32'(ch));
      chk(32'(u_host.stalls), 32'h0000_0000);
    end
    report_and_stop();
  end
endmodule
